//--- design/psc_pkg.sv
// Purpose: Shared constants of the port statistics counter engine
// Assumes: One status word per cycle at most
// Notes: Counter indices form the per-port read map
`default_nettype none
package psc_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 7;          // Port MACs served
    localparam int PORT_W = 3;             // Port number width
    localparam int LEN_W = 14;             // Frame length width
    localparam int SA_W = 48;              // Source address width
    localparam int CNT_W = 64;             // Storage per counter
    localparam int NARROW_W = 32;          // Width of 32-bit counters
    localparam int NUM_CNT = 43;           // Counter slots per port
    localparam int NUM_IMPL = 18;          // Slots backed by logic
    localparam int IDX_W = 6;              // Counter index width
    // ------------------------------------------------------------
    // Length limits
    // ------------------------------------------------------------
    localparam logic [LEN_W-1:0] MIN_LEN = 14'h0040;   // 64 bytes
    localparam logic [LEN_W-1:0] STD_MAX = 14'h05ee;   // Standard max
    localparam logic [LEN_W-1:0] JUMBO_MAX = 14'h2400; // Jumbo limit
    // ------------------------------------------------------------
    // Counter indices
    // ------------------------------------------------------------
    localparam int C_DROP = 0;      // rx_resource_drop_count
    localparam int C_ALL_BYTE = 1;  // rx_all_byte_count
    localparam int C_BCAST = 2;     // rx_bcast_frame_count
    localparam int C_MCAST = 3;     // rx_mcast_frame_count
    localparam int C_SRC_CHG = 4;   // rx_source_change_count
    localparam int C_SHORT_OK = 5;  // rx_short_good_count
    localparam int C_LONG_OK = 6;   // rx_long_good_count
    localparam int C_SHORT_BAD = 7; // rx_short_bad_count
    localparam int C_LONG_BAD = 8;  // rx_long_bad_count
    localparam int C_UCAST = 9;     // rx_ucast_frame_count
    localparam int C_MISALIGN = 10; // rx_misaligned_count
    localparam int C_CHK_FAIL = 11; // rx_checksum_fail_count
    localparam int C_GOOD_BYTE = 12;// rx_good_byte_count
    localparam int C_JUMBO = 13;    // rx_oversized_allowed_count
    localparam int C_EXCESS = 14;   // rx_excess_length_discard_count
    localparam int C_TX_FRAME = 15; // Transmit frame count
    localparam int C_TX_BYTE = 16;  // Transmit byte count
    localparam int C_SHARED = 17;   // Steered frame count
    // Byte counters are 64-bit, all others 32-bit
    localparam logic [NUM_IMPL-1:0] WIDE_MASK = 18'h11002;
    localparam logic [CNT_W-1:0] CNT_RST = 64'h0;
    // ------------------------------------------------------------
    // Snapshot sequencer
    // ------------------------------------------------------------
    typedef enum logic {
        PSC_S_IDLE = 1'b0,  // Waiting for a capture
        PSC_S_COPY = 1'b1   // Copying the selected row
    } psc_snap_state_e;
endpackage : psc_pkg
`default_nettype wire

//--- design/psc_upd_if.sv
// Purpose: Update request from the classifier to the counter store
// Assumes: Single clock domain
// Notes: inc holds one bit per backed counter
`default_nettype none
interface psc_upd_if;
    logic valid;                              // Update this cycle
    logic [psc_pkg::PORT_W-1:0] port;         // Port to update
    logic [psc_pkg::NUM_IMPL-1:0] inc;        // Counters to bump
    logic [psc_pkg::LEN_W-1:0] len;           // Byte amount
    modport src (output valid, port, inc, len);
    modport dst (input valid, port, inc, len);
endinterface : psc_upd_if
`default_nettype wire

//--- design/psc_classify.sv
// Purpose: Turns one status word into counter increment flags
// Assumes: Status fields valid with i_valid
// Notes: One cycle of latency; keeps last good source per port
`default_nettype none
module psc_classify (
    input wire logic i_clk,                               // Clock
    input wire logic i_rstn,                              // Async reset
    input wire logic i_valid,                             // Word valid
    input wire logic i_tx,                                // 1 = transmit
    input wire logic [psc_pkg::PORT_W-1:0] i_port,        // Port
    input wire logic [psc_pkg::LEN_W-1:0] i_len,          // Length
    input wire logic i_fcs_bad,                           // Bad FCS
    input wire logic i_nonint,                            // Odd bits
    input wire logic i_drop,                              // No resources
    input wire logic i_bcast,                             // Broadcast DA
    input wire logic i_mcast,                             // Multicast DA
    input wire logic [psc_pkg::SA_W-1:0] i_sa,            // Source addr
    input wire logic [psc_pkg::NUM_PORTS-1:0] i_shared_tx,// Steering
    input wire logic [psc_pkg::LEN_W-1:0] i_max_len,      // Max size
    psc_upd_if.src u                                      // Update out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [psc_pkg::SA_W-1:0] prev_sa [psc_pkg::NUM_PORTS]; // Last SA
    logic [psc_pkg::SA_W-1:0] next_prev_sa [psc_pkg::NUM_PORTS];
    logic [psc_pkg::NUM_IMPL-1:0] next_inc; // Flags for this word
    logic rx, good, fit, gfit;              // Shorthand terms

    // Classification of the incoming word
    always_comb begin
        rx = i_valid && !i_tx;
        good = !i_fcs_bad;
        fit = i_len <= i_max_len;
        gfit = rx && good && fit;
        next_prev_sa = prev_sa;
        next_inc = '0;
        next_inc[psc_pkg::C_DROP] = gfit && i_drop;
        next_inc[psc_pkg::C_ALL_BYTE] = rx;
        next_inc[psc_pkg::C_BCAST] = gfit && i_bcast;
        next_inc[psc_pkg::C_MCAST] = gfit && i_mcast && !i_bcast;
        next_inc[psc_pkg::C_UCAST] = gfit && !i_mcast && !i_bcast;
        next_inc[psc_pkg::C_SHORT_OK] = rx && good && i_len < psc_pkg::MIN_LEN;
        next_inc[psc_pkg::C_LONG_OK] = rx && good && !fit;
        next_inc[psc_pkg::C_SHORT_BAD] = rx && !good && i_len < psc_pkg::MIN_LEN;
        next_inc[psc_pkg::C_LONG_BAD] = rx && !good && i_len > psc_pkg::STD_MAX;
        next_inc[psc_pkg::C_MISALIGN] = rx && !good && i_nonint
            && i_len >= psc_pkg::MIN_LEN && i_len <= psc_pkg::STD_MAX;
        next_inc[psc_pkg::C_CHK_FAIL] = rx && !good && !i_nonint
            && i_len >= psc_pkg::MIN_LEN && i_len <= psc_pkg::STD_MAX;
        next_inc[psc_pkg::C_GOOD_BYTE] = gfit;
        next_inc[psc_pkg::C_JUMBO] = rx && i_len > psc_pkg::STD_MAX
            && i_len <= psc_pkg::JUMBO_MAX;
        next_inc[psc_pkg::C_EXCESS] = rx && !fit;
        next_inc[psc_pkg::C_TX_FRAME] = i_valid && i_tx;
        next_inc[psc_pkg::C_TX_BYTE] = i_valid && i_tx;
        // Shared group follows the per-port steering bit
        next_inc[psc_pkg::C_SHARED] = i_valid && (i_tx == i_shared_tx[i_port]);
        if (gfit && i_port < psc_pkg::PORT_W'(psc_pkg::NUM_PORTS)) begin
            next_inc[psc_pkg::C_SRC_CHG] = i_sa != prev_sa[i_port];
            next_prev_sa[i_port] = i_sa;
        end
    end

    // Register the update and the source memory
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            u.valid <= 1'b0;
            u.port <= '0;
            u.inc <= '0;
            u.len <= '0;
            for (int p = 0; p < psc_pkg::NUM_PORTS; p++) begin
                prev_sa[p] <= '0;
            end
        end else begin
            u.valid <= i_valid;
            u.port <= i_port;
            u.inc <= next_inc;
            u.len <= i_len;
            prev_sa <= next_prev_sa;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    AST_TX_NO_RX: assert property (i_valid && i_tx |=> u.inc[14:0] == '0)
        else $error("Transmit word bumped a receive counter");
    AST_DROP_EXCL: assert property (u.inc[psc_pkg::C_DROP] |-> !u.inc[psc_pkg::C_EXCESS]
        && !u.inc[psc_pkg::C_MISALIGN] && !u.inc[psc_pkg::C_CHK_FAIL])
        else $error("Drop counted alongside an error count");
    AST_BCAST_GOOD: assert property (rx && i_fcs_bad |=> !u.inc[psc_pkg::C_BCAST]
        && !u.inc[psc_pkg::C_MCAST] && !u.inc[psc_pkg::C_UCAST])
        else $error("Errored frame counted as good traffic");
    AST_SHORT_OK: assert property (rx && !i_fcs_bad && i_len < psc_pkg::MIN_LEN
        |=> u.inc[psc_pkg::C_SHORT_OK] && !u.inc[psc_pkg::C_SHORT_BAD])
        else $error("Short good frame not counted short");
    AST_JUMBO_EDGE: assert property (rx && i_len == psc_pkg::STD_MAX
        |=> !u.inc[psc_pkg::C_JUMBO])
        else $error("Standard-size frame counted as jumbo");
endmodule : psc_classify
`default_nettype wire

//--- design/psc_snapshot.sv
// Purpose: Captures one port's counters into readable storage
// Assumes: Row input follows o_port one cycle after a start
// Notes: Busy is high for exactly the copy cycle
`default_nettype none
module psc_snapshot (
    input wire logic i_clk,                                   // Clock
    input wire logic i_rstn,                                  // Async reset
    input wire logic i_start,                                 // Capture
    input wire logic [psc_pkg::PORT_W-1:0] i_port,            // Port
    input wire logic [psc_pkg::CNT_W-1:0] i_row [psc_pkg::NUM_IMPL], // Live
    output logic [psc_pkg::CNT_W-1:0] o_snap [psc_pkg::NUM_IMPL],   // Copy
    output logic [psc_pkg::PORT_W-1:0] o_port,                // Captured
    output logic o_busy                                       // Copying
);
    psc_pkg::psc_snap_state_e state, next_state; // Sequencer
    logic [psc_pkg::PORT_W-1:0] next_port;       // Port to capture
    logic [psc_pkg::CNT_W-1:0] snap [psc_pkg::NUM_IMPL]; // Storage
    logic [psc_pkg::CNT_W-1:0] next_snap [psc_pkg::NUM_IMPL];

    // Next state; a start while copying is ignored
    always_comb begin
        next_state = state;
        next_port = o_port;
        next_snap = snap;
        case (state)
            psc_pkg::PSC_S_IDLE: begin
                if (i_start) begin
                    next_state = psc_pkg::PSC_S_COPY;
                    next_port = i_port;
                end
            end
            psc_pkg::PSC_S_COPY: begin
                next_snap = i_row;
                next_state = psc_pkg::PSC_S_IDLE;
            end
            default: next_state = psc_pkg::PSC_S_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= psc_pkg::PSC_S_IDLE;
            o_port <= '0;
            for (int i = 0; i < psc_pkg::NUM_IMPL; i++) begin
                snap[i] <= psc_pkg::CNT_RST;
            end
        end else begin
            state <= next_state;
            o_port <= next_port;
            snap <= next_snap;
        end
    end

    assign o_snap = snap;
    assign o_busy = state == psc_pkg::PSC_S_COPY;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_start;
        i_start && !o_busy;
    endsequence
    sequence s_copy_done;
        o_busy ##1 !o_busy;
    endsequence
    AST_SNAP_SEQ: assert property (s_start |=> s_copy_done)
        else $error("Capture busy did not last one cycle");
    AST_SNAP_VAL: assert property (o_busy |=> snap[0] == $past(i_row[0]))
        else $error("Snapshot did not take the live row");
endmodule : psc_snapshot
`default_nettype wire

//--- design/psc_engine.sv
// Purpose: Per-port statistics counter engine with snapshot capture
// Assumes: Status words and read requests synchronous to I_MCLK
// Notes: Counter slots without logic read as zero
`default_nettype none
module psc_engine (
    input wire logic I_MCLK,                                  // Clock
    input wire logic I_RESETN,                                // Async reset
    input wire logic I_STAT_VALID,                            // Word valid
    input wire logic I_STAT_TX,                               // 1 = transmit
    input wire logic [psc_pkg::PORT_W-1:0] I_STAT_PORT,       // Port
    input wire logic [psc_pkg::LEN_W-1:0] I_STAT_LEN,         // Bytes
    input wire logic I_STAT_FCS_BAD,                          // Bad FCS
    input wire logic I_STAT_NONINT,                           // Odd bits
    input wire logic I_STAT_DROP,                             // No buffer
    input wire logic I_STAT_BCAST,                            // Broadcast
    input wire logic I_STAT_MCAST,                            // Multicast
    input wire logic [psc_pkg::SA_W-1:0] I_STAT_SA,           // Source
    input wire logic [psc_pkg::NUM_PORTS-1:0] I_SHARED_TX,    // Steering
    input wire logic [psc_pkg::LEN_W-1:0] I_MAX_LEN,          // Max size
    input wire logic I_SNAP_CAPTURE,                          // Start
    input wire logic I_SNAP_MODE,                             // 1 = mode 11
    input wire logic [psc_pkg::PORT_W-1:0] I_SNAP_PORT,       // Port
    input wire logic I_RD_REQ,                                // Read
    input wire logic I_RD_SNAP,                               // Area
    input wire logic [psc_pkg::PORT_W-1:0] I_RD_PORT,         // Port
    input wire logic [psc_pkg::IDX_W-1:0] I_RD_INDEX,         // Counter
    output logic [psc_pkg::CNT_W-1:0] O_RD_DATA,              // Read data
    output logic O_RD_VALID,                                  // Data valid
    output logic O_SNAP_BUSY,                                 // Capturing
    output logic [psc_pkg::PORT_W-1:0] O_SNAP_PORT            // Captured
);
    // ------------------------------------------------------------
    // Classifier
    // ------------------------------------------------------------
    psc_upd_if upd (); // Increment request

    psc_classify u_classify (
        .i_clk (I_MCLK),
        .i_rstn (I_RESETN),
        .i_valid (I_STAT_VALID),
        .i_tx (I_STAT_TX),
        .i_port (I_STAT_PORT),
        .i_len (I_STAT_LEN),
        .i_fcs_bad (I_STAT_FCS_BAD),
        .i_nonint (I_STAT_NONINT),
        .i_drop (I_STAT_DROP),
        .i_bcast (I_STAT_BCAST),
        .i_mcast (I_STAT_MCAST),
        .i_sa (I_STAT_SA),
        .i_shared_tx (I_SHARED_TX),
        .i_max_len (I_MAX_LEN),
        .u (upd.src)
    );

    // ------------------------------------------------------------
    // Live counters
    // ------------------------------------------------------------
    // Only the backed slots hold flops; the rest of the 43 read zero
    logic [psc_pkg::CNT_W-1:0] cnt [psc_pkg::NUM_PORTS][psc_pkg::NUM_IMPL];
    logic [psc_pkg::CNT_W-1:0] next_cnt [psc_pkg::NUM_PORTS][psc_pkg::NUM_IMPL];

    genvar gp, gi;
    generate
        for (gp = 0; gp < psc_pkg::NUM_PORTS; gp++) begin : g_port
            for (gi = 0; gi < psc_pkg::NUM_IMPL; gi++) begin : g_cnt
                logic [psc_pkg::CNT_W-1:0] sum; // Raw sum before wrap
                // Bump by length or by one, wrapping at own width
                always_comb begin
                    sum = cnt[gp][gi] + (psc_pkg::WIDE_MASK[gi]
                        ? {50'h0, upd.len} : 64'h1);
                    next_cnt[gp][gi] = cnt[gp][gi];
                    if (upd.valid && upd.inc[gi]
                        && upd.port == psc_pkg::PORT_W'(gp)) begin
                        if (psc_pkg::WIDE_MASK[gi]) begin
                            next_cnt[gp][gi] = sum;
                        end else begin
                            next_cnt[gp][gi] = {32'h0, sum[31:0]};
                        end
                    end
                end
                // Counter register
                always_ff @(posedge I_MCLK or negedge I_RESETN) begin
                    if (!I_RESETN) begin
                        cnt[gp][gi] <= psc_pkg::CNT_RST;
                    end else begin
                        cnt[gp][gi] <= next_cnt[gp][gi];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Snapshot
    // ------------------------------------------------------------
    logic [psc_pkg::CNT_W-1:0] snap [psc_pkg::NUM_IMPL]; // Captured row
    logic [psc_pkg::CNT_W-1:0] cap_row [psc_pkg::NUM_IMPL]; // Live row
    logic [psc_pkg::PORT_W-1:0] cap_port; // Port held by the copy
    logic snap_busy; // Copy in progress

    // Live row of the port being captured; copy never stalls counting
    always_comb begin
        for (int i = 0; i < psc_pkg::NUM_IMPL; i++) begin
            cap_row[i] = '0;
            if (cap_port < psc_pkg::PORT_W'(psc_pkg::NUM_PORTS)) begin
                cap_row[i] = cnt[cap_port][i];
            end
        end
    end

    psc_snapshot u_snapshot (
        .i_clk (I_MCLK),
        .i_rstn (I_RESETN),
        .i_start (I_SNAP_CAPTURE),
        .i_port (I_SNAP_PORT),
        .i_row (cap_row),
        .o_snap (snap),
        .o_port (cap_port),
        .o_busy (snap_busy)
    );

    assign O_SNAP_BUSY = snap_busy;
    assign O_SNAP_PORT = cap_port;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [psc_pkg::CNT_W-1:0] next_rd_data; // Selected value
    logic in_map; // Index and port are backed

    // Area choice; reads never touch the counters themselves
    always_comb begin
        in_map = I_RD_INDEX < psc_pkg::IDX_W'(psc_pkg::NUM_IMPL)
            && I_RD_PORT < psc_pkg::PORT_W'(psc_pkg::NUM_PORTS);
        next_rd_data = '0;
        if (I_RD_REQ && I_RD_INDEX < psc_pkg::IDX_W'(psc_pkg::NUM_IMPL)) begin
            if (I_RD_SNAP) begin
                // Snapshot area; stale until the copy cycle ends
                next_rd_data = snap[I_RD_INDEX[4:0]];
            end else if (I_SNAP_MODE) begin
                // Live area shows the capture for that port only
                if (I_RD_PORT == cap_port) begin
                    next_rd_data = snap[I_RD_INDEX[4:0]];
                end
            end else if (in_map) begin
                next_rd_data = cnt[I_RD_PORT][I_RD_INDEX[4:0]];
            end
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_RD_DATA <= psc_pkg::CNT_RST;
            O_RD_VALID <= 1'b0;
        end else begin
            O_RD_DATA <= next_rd_data;
            O_RD_VALID <= I_RD_REQ;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);

    AST_RD_LATENCY: assert property (I_RD_REQ |=> O_RD_VALID)
        else $error("Read answer not one cycle after request");
    AST_NARROW_WRAP: assert property (cnt[1][psc_pkg::C_BCAST][63:32] == 32'h0)
        else $error("32-bit counter grew past its width");
    AST_LIVE_HIDDEN: assert property (I_RD_REQ && !I_RD_SNAP && I_SNAP_MODE
        && I_RD_PORT != cap_port |=> O_RD_DATA == 64'h0)
        else $error("Live counter visible in mode 11");
    AST_IDLE_HOLD: assert property (!upd.valid |=> $stable(cnt[1][psc_pkg::C_ALL_BYTE]))
        else $error("Counter moved without an update");
    AST_BYTE_ADD: assert property (upd.valid && upd.port == 3'h1
        && upd.inc[psc_pkg::C_GOOD_BYTE] |=> cnt[1][psc_pkg::C_GOOD_BYTE]
        == $past(cnt[1][psc_pkg::C_GOOD_BYTE]) + {50'h0, $past(upd.len)})
        else $error("Good byte counter did not add the length");
    AST_MAX_PROG: assert property (I_STAT_VALID && !I_STAT_TX && !I_STAT_FCS_BAD
        && I_STAT_LEN > I_MAX_LEN |=> !upd.inc[psc_pkg::C_GOOD_BYTE]
        && upd.inc[psc_pkg::C_LONG_OK])
        else $error("Programmed maximum not applied");
endmodule : psc_engine
`default_nettype wire

//--- bench/psc_mac_model.sv
// Purpose: Port MAC model that hands status words to the engine
// Assumes: One word per call, valid for exactly one cycle
// Notes: Fields invert once released so stale values never look valid
`default_nettype none
module psc_mac_model (
    input wire logic i_clk, // Clock
    output logic o_valid, // Word valid
    output logic o_tx, // 1 = transmit
    output logic [2:0] o_port, // Port
    output logic [13:0] o_len, // Length
    output logic [4:0] o_flags, // Fcs, nonint, drop, bcast, mcast
    output logic [47:0] o_sa // Source address
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // Word driver
    // ----------------
    initial begin
        o_valid = 1'b0;
        {o_tx, o_port, o_len, o_flags, o_sa} = '0;
    end
    // Hold word for one edge, then scramble so the engine must gate on valid
    task automatic send(input logic t, input logic [2:0] p, input logic [13:0] l,
            input logic [4:0] f, input logic [47:0] s);
        @(posedge i_clk);
        o_valid <= 1'b1;
        {o_tx, o_port, o_len, o_flags, o_sa} <= {t, p, l, f, s};
        @(posedge i_clk);
        o_valid <= 1'b0;
        {o_tx, o_port, o_len, o_flags, o_sa} <= ~{t, p, l, f, s};
    endtask : send
endmodule : psc_mac_model
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: Directed bench for the port statistics counter engine
// Assumes: Partner MAC model feeds status words
// Notes: Expected counts are worked out by hand from the frames sent
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // Stimulus and checks
    // ----------------
    logic I_MCLK = 1'b0, I_RESETN = 1'b0, I_SNAP_CAPTURE = 1'b0, I_SNAP_MODE = 1'b0;
    logic I_RD_REQ = 1'b0, I_RD_SNAP = 1'b0, v, tx, rv, bsy;
    logic [2:0] I_SNAP_PORT = 3'h0, I_RD_PORT = 3'h0, p, sp;
    logic [5:0] I_RD_INDEX = 6'h00;
    logic [6:0] I_SHARED_TX = 7'h02; // Port 1 steers shared group to transmit
    logic [13:0] I_MAX_LEN = 14'h05ee, len;
    logic [4:0] f;
    logic [47:0] sa;
    logic [63:0] d;
    int miscompares = 0, samples_checked = 0;
    localparam logic [63:0] EXP [18] = '{'h1, 'h160e, 'h1, 'h1, 'h3, 'h1, 'h1, 'h1, 'h1,
        'h2, 'h1, 'h1, 'h1a8, 'h2, 'h2, 'h1, 'h12c, 'h1};
    always #2 I_MCLK = ~I_MCLK;
    psc_mac_model mac_u (.i_clk(I_MCLK), .o_valid(v), .o_tx(tx), .o_port(p), .o_len(len),
        .o_flags(f), .o_sa(sa));
    psc_engine dut_u (.I_MCLK, .I_RESETN, .I_STAT_VALID(v), .I_STAT_TX(tx), .I_STAT_PORT(p),
        .I_STAT_LEN(len), .I_STAT_FCS_BAD(f[4]), .I_STAT_NONINT(f[3]), .I_STAT_DROP(f[2]),
        .I_STAT_BCAST(f[1]), .I_STAT_MCAST(f[0]), .I_STAT_SA(sa), .I_SHARED_TX, .I_MAX_LEN,
        .I_SNAP_CAPTURE, .I_SNAP_MODE, .I_SNAP_PORT, .I_RD_REQ, .I_RD_SNAP, .I_RD_PORT,
        .I_RD_INDEX, .O_RD_DATA(d), .O_RD_VALID(rv), .O_SNAP_BUSY(bsy), .O_SNAP_PORT(sp));
    task automatic chk(input string n, input logic [64:0] e, input logic [64:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Read request held one edge, answer checked in the cycle it stands
    task automatic rd(input logic s, input logic [2:0] pt, input logic [5:0] ix,
            input logic [63:0] e);
        @(posedge I_MCLK);
        {I_RD_REQ, I_RD_SNAP, I_RD_PORT, I_RD_INDEX} <= {1'b1, s, pt, ix};
        @(posedge I_MCLK);
        I_RD_REQ <= 1'b0;
        #1;
        chk("read_data", {e, 1'b1}, {d, rv});
    endtask : rd
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog, far beyond the roughly 120 cycles the tests need
    initial begin
        repeat (5000) @(posedge I_MCLK);
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge I_MCLK);
        I_RESETN <= 1'b1;
        mac_u.send(1'b0, 3'h1, 14'h0064, 5'h00, 48'h1);
        mac_u.send(1'b0, 3'h1, 14'h003c, 5'h02, 48'h1);
        mac_u.send(1'b0, 3'h1, 14'h0040, 5'h01, 48'h2);
        mac_u.send(1'b0, 3'h1, 14'h0040, 5'h18, 48'h2);
        mac_u.send(1'b0, 3'h1, 14'h05ee, 5'h10, 48'h2);
        mac_u.send(1'b0, 3'h1, 14'h0028, 5'h10, 48'h2);
        mac_u.send(1'b0, 3'h1, 14'h07d0, 5'h10, 48'h2);
        mac_u.send(1'b0, 3'h1, 14'h0640, 5'h04, 48'h2);
        mac_u.send(1'b0, 3'h1, 14'h00c8, 5'h04, 48'h3);
        mac_u.send(1'b1, 3'h1, 14'h012c, 5'h00, 48'h3);
        for (int i = 0; i < 18; i++) rd(1'b0, 3'h1, 6'(i), EXP[i]);
        rd(1'b0, 3'h1, 6'h14, 64'h0);
        I_MAX_LEN <= 14'h07d0;
        mac_u.send(1'b0, 3'h2, 14'h0640, 5'h00, 48'h1);
        rd(1'b0, 3'h2, 6'h09, 64'h1);
        rd(1'b0, 3'h2, 6'h11, 64'h1);
        @(posedge I_MCLK);
        {I_SNAP_CAPTURE, I_SNAP_PORT} <= 4'h9;
        @(posedge I_MCLK);
        I_SNAP_CAPTURE <= 1'b0;
        #1;
        chk("snap_busy", 65'h9, {61'h0, bsy, sp});
        mac_u.send(1'b0, 3'h1, 14'h0064, 5'h00, 48'h3);
        chk("snap_idle", 65'h1, {61'h0, bsy, sp});
        for (int i = 0; i < 18; i++) rd(1'b1, 3'h1, 6'(i), EXP[i]);
        rd(1'b0, 3'h1, 6'h09, 64'h3);
        I_SNAP_MODE <= 1'b1;
        rd(1'b0, 3'h1, 6'h09, 64'h2);
        rd(1'b0, 3'h2, 6'h09, 64'h0);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
